// ==== logic/relay_pkg.sv ====
package relay_pkg;
	// ==========================================================
	// Timing
	localparam int unsigned CLOCK_HZ = 10_000_000;
	localparam int unsigned SAMPLE_PERIOD_MS = 10;
	localparam int unsigned LINK_TIMEOUT_MS = 50;
	localparam int unsigned CYCLES_PER_MS = CLOCK_HZ / 1000;
	localparam int unsigned SAMPLE_CYCLES = SAMPLE_PERIOD_MS * CYCLES_PER_MS;
	localparam int unsigned TIMEOUT_CYCLES = LINK_TIMEOUT_MS * CYCLES_PER_MS;
	localparam int unsigned COUNT_WIDTH = 24;
	localparam int unsigned PLL_MULTIPLIER = 40;
	localparam int unsigned PHY_CLOCK_MHZ = 480;

	// ==========================================================
	// Data path
	localparam int unsigned BYTE_WIDTH = 8;
	localparam int unsigned LINK_WIDTH = 9;
	localparam int unsigned FIFO_DEPTH = 32;
	localparam int unsigned SIDEBAND_COUNT = 3;

	// ==========================================================
	// Link word layout: bit 8 marks a sideband word
	localparam int unsigned LINK_MARK_BIT = 8;
	localparam int unsigned SB_ROLE_BIT = 3;
	localparam int unsigned SB_DOWN_A_BIT = 0;
	localparam int unsigned SB_UP_A_BIT = 1;
	localparam int unsigned SB_UP_B_BIT = 2;

	// ==========================================================
	// Roles and speeds
	localparam logic ROLE_HOST = 1'h1;
	localparam logic ROLE_REMOTE = 1'h0;
	localparam logic [2:0] SPEED_HIGH_ONLY = 3'h4;
	localparam logic [2:0] SPEED_ALL = 3'h7;

	typedef enum logic [1:0] {
		LINK_WAIT_CLOCK = 2'h0,
		LINK_SEARCH = 2'h1,
		LINK_CONNECTED = 2'h3,
		LINK_LOST = 2'h2
	} link_state_type;
endpackage

// ==== logic/level_sync.sv ====
`timescale 1ns/1ps
module level_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic clock,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	typedef struct packed {
		logic [WIDTH-1:0] first;
		logic [WIDTH-1:0] second;
	} sync_state_type;

	sync_state_type state;
	sync_state_type next_state;

	// No reset: the strap must pass through while reset is held
	always_comb begin
		next_state.first = async_in;
		next_state.second = state.first;
	end

	always_ff @(posedge clock) begin
		state <= next_state;
	end

	assign sync_out = state.second;
endmodule

// ==== logic/word_fifo.sv ====
`timescale 1ns/1ps
module word_fifo #(
	parameter int unsigned WIDTH = 8,
	parameter int unsigned DEPTH = 32
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int unsigned AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0] wr_ptr;
		logic [AW-1:0] rd_ptr;
		logic [AW:0] count;
	} fifo_state_type;

	fifo_state_type state;
	fifo_state_type next_state;
	logic do_write;
	logic do_read;

	always_comb begin
		in_ready = state.count != (AW+1)'(DEPTH);
		out_valid = state.count != '0;
		out_data = state.mem[state.rd_ptr];
		do_write = in_valid && in_ready;
		do_read = out_valid && out_ready;
		next_state = state;
		if (do_write) begin
			next_state.mem[state.wr_ptr] = in_data;
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (do_read) begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		end
		if (do_write && !do_read) begin
			next_state.count = state.count + 1'b1;
		end else if (do_read && !do_write) begin
			next_state.count = state.count - 1'b1;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			state.wr_ptr <= '0;
			state.rd_ptr <= '0;
			state.count <= '0;
			state.mem <= state.mem;
		end else begin
			state <= next_state;
		end
	end
endmodule

// ==== logic/usb_isolation_extender_ctrl.sv ====
`timescale 1ns/1ps
module usb_isolation_extender_ctrl #(
	parameter int unsigned SAMPLE_TICKS = relay_pkg::SAMPLE_CYCLES,
	parameter int unsigned TIMEOUT_TICKS = relay_pkg::TIMEOUT_CYCLES
) (
	input wire logic clock,
	input wire logic reset,
	// Strap and status pin
	input wire logic status_role_strap_in,
	output logic status_role_strap_out,
	output logic status_role_strap_oe_n,
	// Sideband pins
	input wire logic sideband_down_a_in,
	output logic sideband_down_a_out,
	output logic sideband_down_a_oe_n,
	input wire logic sideband_up_a_in,
	output logic sideband_up_a_out,
	output logic sideband_up_a_oe_n,
	input wire logic sideband_up_b_in,
	output logic sideband_up_b_out,
	output logic sideband_up_b_oe_n,
	// PLL
	input wire logic pll_locked,
	output logic pll_enable,
	output logic [7:0] pll_multiplier,
	// USB port configuration
	output logic port_a_upstream,
	output logic port_a_downstream,
	output logic port_b_downstream,
	output logic hub_mode,
	output logic [2:0] port_a_speeds,
	output logic [2:0] port_b_speeds,
	// USB stream from the ports toward the link
	input wire logic [relay_pkg::BYTE_WIDTH-1:0] usb_rx_data,
	input wire logic usb_rx_valid,
	output logic usb_rx_ready,
	// USB stream from the link toward the ports
	output logic [relay_pkg::BYTE_WIDTH-1:0] usb_tx_data,
	output logic usb_tx_valid,
	// Link word interface to the line driver
	output logic [relay_pkg::LINK_WIDTH-1:0] link_tx_data,
	output logic link_tx_valid,
	input wire logic link_tx_ready,
	input wire logic [relay_pkg::LINK_WIDTH-1:0] link_rx_data,
	input wire logic link_rx_valid,
	output logic link_connected
);
	import relay_pkg::*;

	// ==========================================================
	// State
	typedef struct packed {
		logic role;
		link_state_type link;
		logic [COUNT_WIDTH-1:0] sample_count;
		logic [COUNT_WIDTH-1:0] idle_count;
		logic sb_pending;
		logic tx_valid;
		logic [LINK_WIDTH-1:0] tx_data;
		logic usb_valid;
		logic [BYTE_WIDTH-1:0] usb_data;
		logic [SIDEBAND_COUNT-1:0] sb_out;
		logic [SIDEBAND_COUNT-1:0] sb_oe_n;
		logic status_oe_n;
		logic port_a_up;
		logic port_a_down;
		logic port_b_down;
		logic hub;
		logic [2:0] speeds_a;
		logic [2:0] speeds_b;
		logic pll_en;
		logic connected;
	} ctrl_state_type;

	ctrl_state_type state;
	ctrl_state_type next_state;

	localparam logic [COUNT_WIDTH-1:0] SAMPLE_LAST =
		COUNT_WIDTH'(SAMPLE_TICKS - 1);
	localparam logic [COUNT_WIDTH-1:0] TIMEOUT_LAST =
		COUNT_WIDTH'(TIMEOUT_TICKS - 1);

	// ==========================================================
	// Synchronisers for everything arriving from pins
	logic [4:0] pin_sync;
	logic strap_level;
	logic [SIDEBAND_COUNT-1:0] sb_level;
	logic lock_level;

	level_sync #(
		.WIDTH(5)
	) pin_sync_bank (
		.clock(clock),
		.async_in({pll_locked, sideband_up_b_in, sideband_up_a_in,
			sideband_down_a_in, status_role_strap_in}),
		.sync_out(pin_sync)
	);

	assign strap_level = pin_sync[0];
	assign sb_level = pin_sync[3:1];
	assign lock_level = pin_sync[4];

	// ==========================================================
	// Stream buffer toward the link
	logic [BYTE_WIDTH-1:0] fifo_data;
	logic fifo_valid;
	logic fifo_ready;

	word_fifo #(
		.WIDTH(BYTE_WIDTH),
		.DEPTH(FIFO_DEPTH)
	) stream_fifo (
		.clock(clock),
		.reset(reset),
		.in_data(usb_rx_data),
		.in_valid(usb_rx_valid),
		.in_ready(usb_rx_ready),
		.out_data(fifo_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_ready)
	);

	// ==========================================================
	// Helpers
	function automatic logic [LINK_WIDTH-1:0] sideband_word(
		input logic role,
		input logic [SIDEBAND_COUNT-1:0] levels
	);
		logic [LINK_WIDTH-1:0] word;
		word = '0;
		word[LINK_MARK_BIT] = 1'b1;
		word[SB_ROLE_BIT] = role;
		word[SIDEBAND_COUNT-1:0] = levels;
		return word;
	endfunction

	function automatic logic is_sideband(input logic [LINK_WIDTH-1:0] word);
		return word[LINK_MARK_BIT];
	endfunction

	// Role decode is shared by the port map and the pin directions
	function automatic logic role_is_host(input logic role);
		return role == ROLE_HOST;
	endfunction

	logic slot_free;
	logic rx_data_word;
	logic rx_sb_word;
	logic peer_opposite;
	logic sample_tick;

	// ==========================================================
	// Next state
	always_comb begin
		next_state = state;
		slot_free = !state.tx_valid || link_tx_ready;
		rx_data_word = link_rx_valid && !is_sideband(link_rx_data);
		rx_sb_word = link_rx_valid && is_sideband(link_rx_data);
		peer_opposite = link_rx_data[SB_ROLE_BIT] != state.role;
		sample_tick = state.sample_count == SAMPLE_LAST;
		fifo_ready = 1'b0;

		// Port map follows the latched role
		next_state.port_a_up = role_is_host(state.role);
		next_state.port_a_down = state.role == ROLE_REMOTE;
		next_state.port_b_down = 1'b1;
		next_state.hub = role_is_host(state.role);
		next_state.speeds_a = role_is_host(state.role) ?
			SPEED_HIGH_ONLY : SPEED_ALL;
		next_state.speeds_b = SPEED_ALL;
		next_state.pll_en = 1'b1;

		// Pin directions follow the role
		// Directions are registered so a pin never flips mid-cycle
		next_state.sb_oe_n[SB_DOWN_A_BIT] = role_is_host(state.role);
		next_state.sb_oe_n[SB_UP_A_BIT] = state.role == ROLE_REMOTE;
		next_state.sb_oe_n[SB_UP_B_BIT] = state.role == ROLE_REMOTE;

		// Periodic sampling of the sideband inputs
		// Coarse sampling keeps link traffic low at the cost of latency
		if (sample_tick) begin
			next_state.sample_count = '0;
			next_state.sb_pending = state.link != LINK_WAIT_CLOCK;
		end else begin
			next_state.sample_count = state.sample_count + 1'b1;
		end

		// Link output: sideband words take the slot first, then stream data
		if (slot_free) begin
			next_state.tx_valid = 1'b0;
			if (state.sb_pending) begin
				next_state.tx_valid = 1'b1;
				next_state.tx_data = sideband_word(state.role, sb_level);
				next_state.sb_pending = sample_tick &&
					state.link != LINK_WAIT_CLOCK;
			end else if (fifo_valid && state.link != LINK_WAIT_CLOCK) begin
				fifo_ready = 1'b1;
				next_state.tx_valid = 1'b1;
				next_state.tx_data = {1'b0, fifo_data};
			end
		end

		// Stream words from the peer go straight out, every transfer type
		next_state.usb_valid = rx_data_word;
		if (rx_data_word) begin
			next_state.usb_data = link_rx_data[BYTE_WIDTH-1:0];
		end

		// Silence watchdog
		// Saturates, so a long silence never wraps into a false link
		if (link_rx_valid) begin
			next_state.idle_count = '0;
		end else if (state.idle_count != TIMEOUT_LAST) begin
			next_state.idle_count = state.idle_count + 1'b1;
		end

		case (state.link)
			LINK_WAIT_CLOCK: begin
				if (lock_level) begin
					next_state.link = LINK_SEARCH;
				end
			end
			LINK_SEARCH: begin
				if (rx_sb_word && peer_opposite) begin
					next_state.link = LINK_CONNECTED;
				end
			end
			LINK_CONNECTED: begin
				if (!lock_level || state.idle_count == TIMEOUT_LAST) begin
					next_state.link = LINK_LOST;
				end
			end
			LINK_LOST: begin
				next_state.link = lock_level ? LINK_SEARCH : LINK_WAIT_CLOCK;
			end
			default: begin
				next_state.link = LINK_WAIT_CLOCK;
			end
		endcase

		next_state.connected = next_state.link == LINK_CONNECTED;
		// Open drain: pull low only while connected, else pull-up wins
		next_state.status_oe_n = !next_state.connected;

		// Peer levels apply only while connected; a lost link holds them
		if (rx_sb_word && peer_opposite && state.link == LINK_CONNECTED) begin
			// Only the pins that are outputs in this role take peer levels
			if (role_is_host(state.role)) begin
				next_state.sb_out[SB_UP_A_BIT] =
					link_rx_data[SB_UP_A_BIT];
				next_state.sb_out[SB_UP_B_BIT] =
					link_rx_data[SB_UP_B_BIT];
			end else begin
				next_state.sb_out[SB_DOWN_A_BIT] =
					link_rx_data[SB_DOWN_A_BIT];
			end
		end
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clock) begin
		if (reset) begin
			// The strap pin is not driven during reset, so its level
			// is the external strap; role freezes when reset falls
			state.role <= strap_level ? ROLE_HOST : ROLE_REMOTE;
			state.link <= LINK_WAIT_CLOCK;
			state.sample_count <= '0;
			state.idle_count <= '0;
			state.sb_pending <= 1'b0;
			state.tx_valid <= 1'b0;
			state.tx_data <= '0;
			state.usb_valid <= 1'b0;
			state.usb_data <= '0;
			state.sb_out <= '0;
			state.sb_oe_n <= '1;
			state.status_oe_n <= 1'b1;
			state.port_a_up <= 1'b0;
			state.port_a_down <= 1'b0;
			state.port_b_down <= 1'b0;
			state.hub <= 1'b0;
			state.speeds_a <= 3'h0;
			state.speeds_b <= 3'h0;
			state.pll_en <= 1'b0;
			state.connected <= 1'b0;
		end else begin
			state <= next_state;
		end
	end

	// ==========================================================
	// Outputs
	assign status_role_strap_out = 1'b0;
	assign status_role_strap_oe_n = state.status_oe_n;
	assign sideband_down_a_out = state.sb_out[SB_DOWN_A_BIT];
	assign sideband_down_a_oe_n = state.sb_oe_n[SB_DOWN_A_BIT];
	assign sideband_up_a_out = state.sb_out[SB_UP_A_BIT];
	assign sideband_up_a_oe_n = state.sb_oe_n[SB_UP_A_BIT];
	assign sideband_up_b_out = state.sb_out[SB_UP_B_BIT];
	assign sideband_up_b_oe_n = state.sb_oe_n[SB_UP_B_BIT];
	assign pll_enable = state.pll_en;
	assign pll_multiplier = 8'(PLL_MULTIPLIER);
	assign port_a_upstream = state.port_a_up;
	assign port_a_downstream = state.port_a_down;
	assign port_b_downstream = state.port_b_down;
	assign hub_mode = state.hub;
	assign port_a_speeds = state.speeds_a;
	assign port_b_speeds = state.speeds_b;
	assign usb_tx_data = state.usb_data;
	assign usb_tx_valid = state.usb_valid;
	assign link_tx_data = state.tx_data;
	assign link_tx_valid = state.tx_valid;
	assign link_connected = state.connected;
endmodule

// ==== testbench/peer_model.sv ====
`timescale 1ns/1ps
module peer_model (
	input wire logic clock,
	input wire logic reset,
	input wire logic enable,
	input wire logic role,
	input wire logic [2:0] levels,
	input wire logic stall,
	input wire logic [8:0] link_tx_data,
	input wire logic link_tx_valid,
	output logic link_tx_ready,
	output logic [8:0] link_rx_data = 9'h000,
	output logic link_rx_valid = 1'b0
);
	logic [8:0] txq[$];
	logic [8:0] got[$];
	logic [8:0] last_sb = 9'h000;
	int tick = 0;
	// A stalled peer refuses every word, sideband ones too
	assign link_tx_ready = !stall;
	task send(input logic [8:0] w);
		txq.push_back(w);
	endtask
	always @(posedge clock) begin
		if (link_tx_valid && link_tx_ready) begin
			if (link_tx_data[8]) begin
				last_sb <= link_tx_data;
			end else begin
				got.push_back(link_tx_data);
			end
		end
		tick <= (tick == 15) ? 0 : tick + 1;
		if (txq.size() > 0) begin
			link_rx_data <= txq.pop_front();
			link_rx_valid <= 1'b1;
		end else if (enable && tick == 0) begin
			link_rx_data <= {1'b1, 4'h0, role, levels};
			link_rx_valid <= 1'b1;
		end else begin
			// Idle line inverts every bit each cycle, so it shows the last word again every other cycle
			link_rx_data <= ~link_rx_data;
			link_rx_valid <= 1'b0;
		end
	end
endmodule

// ==== testbench/usb_isolation_extender_ctrl_checker.sv ====
`timescale 1ns/1ps
module relay_checker import relay_pkg::*; #(
	parameter int unsigned SAMPLE_TICKS = 16,
	parameter int unsigned TIMEOUT_TICKS = 64
) (
	input wire logic clock,
	input wire logic reset,
	input wire logic status_role_strap_out,
	input wire logic status_role_strap_oe_n,
	input wire logic sideband_down_a_oe_n,
	input wire logic sideband_up_a_oe_n,
	input wire logic sideband_up_b_oe_n,
	input wire logic pll_enable,
	input wire logic [7:0] pll_multiplier,
	input wire logic port_a_upstream,
	input wire logic port_a_downstream,
	input wire logic port_b_downstream,
	input wire logic hub_mode,
	input wire logic [2:0] port_a_speeds,
	input wire logic [2:0] port_b_speeds,
	input wire logic usb_rx_valid,
	input wire logic usb_rx_ready,
	input wire logic [7:0] usb_tx_data,
	input wire logic usb_tx_valid,
	input wire logic [8:0] link_tx_data,
	input wire logic link_tx_valid,
	input wire logic link_tx_ready,
	input wire logic [8:0] link_rx_data,
	input wire logic link_rx_valid,
	input wire logic link_connected
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);
	// ==========================================================
	// Helpers
	logic [7:0] rx_byte;
	int unsigned quiet;
	always_ff @(posedge clock) begin
		rx_byte <= link_rx_data[7:0];
		if (reset || link_rx_valid) quiet <= 0;
		else if (quiet < 100000) quiet <= quiet + 1;
	end
	logic cfg;
	assign cfg = port_a_upstream || port_a_downstream;
	// ==========================================================
	// Assertions
	a_status_on_connect: assert property ($rose(link_connected) |->
		!status_role_strap_oe_n) else $error("status not low");
	a_status_open_drain: assert property (!status_role_strap_out)
		else $error("status data not low");
	a_lost_release: assert property ($fell(link_connected) |->
		##[0:2] status_role_strap_oe_n) else $error("status not released");
	a_lost_timeout: assert property (link_connected |->
		quiet <= TIMEOUT_TICKS + 3) else $error("silent link kept");
	a_host_dirs: assert property (port_a_upstream |-> sideband_down_a_oe_n
		&& !sideband_up_a_oe_n && !sideband_up_b_oe_n)
		else $error("host directions");
	a_remote_dirs: assert property (port_a_downstream |->
		!sideband_down_a_oe_n && sideband_up_a_oe_n && sideband_up_b_oe_n)
		else $error("remote directions");
	a_port_roles: assert property (cfg |-> (port_a_upstream ^
		port_a_downstream) && port_b_downstream && hub_mode == port_a_upstream)
		else $error("port roles");
	a_speed_mask: assert property (cfg |-> port_b_speeds == SPEED_ALL &&
		port_a_speeds == (port_a_upstream ? SPEED_HIGH_ONLY : SPEED_ALL))
		else $error("speed masks");
	a_role_held: assert property (cfg |=> $stable(port_a_upstream))
		else $error("role changed");
	a_pll_setup: assert property (cfg |=> pll_enable &&
		pll_multiplier == 8'h28) else $error("pll setup");
	a_tx_hold: assert property (link_tx_valid && !link_tx_ready |=>
		link_tx_valid && $stable(link_tx_data)) else $error("tx word dropped");
	a_rx_relay: assert property (link_rx_valid && !link_rx_data[8] |=>
		usb_tx_valid && usb_tx_data == rx_byte) else $error("rx byte lost");
	a_sb_format: assert property (link_tx_valid && link_tx_data[8] |->
		link_tx_data[7:3] == {4'h0, port_a_upstream})
		else $error("sideband word format");
	c_connect: cover property ($rose(link_connected));
	c_lost: cover property ($fell(link_connected));
	c_full: cover property (usb_rx_valid && !usb_rx_ready);
endmodule
bind usb_isolation_extender_ctrl relay_checker #(
	.SAMPLE_TICKS(SAMPLE_TICKS),
	.TIMEOUT_TICKS(TIMEOUT_TICKS)
) relay_checker_i (.*);

// ==== testbench/usb_isolation_extender_ctrl_tb_top.sv ====
`timescale 1ns/1ps
module usb_isolation_extender_ctrl_tb_top;
	import relay_pkg::*;
	localparam int unsigned TT = 64;
	logic clock = 1'b0, reset = 1'b1, strap_pull = 1'b1, pll_locked = 1'b0;
	logic [2:0] lvl = 3'h0, peer_lvl = 3'h0;
	logic [7:0] usb_rx_data = 8'h00;
	logic usb_rx_valid = 1'b0, peer_en = 1'b0, peer_role = 1'b0, stall = 1'b0;
	logic status_role_strap_in, status_role_strap_out, status_role_strap_oe_n;
	logic sideband_down_a_in, sideband_down_a_out, sideband_down_a_oe_n;
	logic sideband_up_a_in, sideband_up_a_out, sideband_up_a_oe_n;
	logic sideband_up_b_in, sideband_up_b_out, sideband_up_b_oe_n;
	logic pll_enable, port_a_upstream, port_a_downstream, port_b_downstream;
	logic hub_mode, usb_rx_ready, usb_tx_valid, link_connected;
	logic link_tx_valid, link_tx_ready, link_rx_valid;
	logic [7:0] pll_multiplier, usb_tx_data;
	logic [2:0] port_a_speeds, port_b_speeds;
	logic [8:0] link_tx_data, link_rx_data;
	int n_mismatch = 0;
	int num_checks = 0;
	int acc;
	logic [7:0] tx_seen[$];
	// Open-drain strap with board pull; sideband pins resolved by enables
	assign status_role_strap_in = status_role_strap_oe_n ? strap_pull
		: status_role_strap_out;
	assign sideband_down_a_in = sideband_down_a_oe_n ? lvl[0]
		: sideband_down_a_out;
	assign sideband_up_a_in = sideband_up_a_oe_n ? lvl[1] : sideband_up_a_out;
	assign sideband_up_b_in = sideband_up_b_oe_n ? lvl[2] : sideband_up_b_out;
	usb_isolation_extender_ctrl #(
		.SAMPLE_TICKS(16),
		.TIMEOUT_TICKS(TT)
	) usb_isolation_extender_ctrl_i (.*);
	peer_model peer_model_i (.clock, .reset, .enable(peer_en),
		.role(peer_role), .levels(peer_lvl), .stall, .link_tx_data,
		.link_tx_valid, .link_tx_ready, .link_rx_data, .link_rx_valid);
	initial begin
		forever #50 clock = ~clock;
	end
	always @(posedge clock) begin
		if (usb_tx_valid === 1'b1) tx_seen.push_back(usb_tx_data);
	end
	// ==========================================================
	// Tasks
	task chk(input string name, input logic [8:0] exp, input logic [8:0] got);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task done(input string name);
		$display("test %s finished", name);
	endtask
	task results;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task do_reset(input logic pull);
		strap_pull <= pull;
		reset <= 1'b1;
		repeat (8) @(posedge clock);
		reset <= 1'b0;
		repeat (4) @(posedge clock);
	endtask
	task cfg(input logic h);
		chk("ports", {5'h00, h, !h, 1'b1, h}, {5'h00, port_a_upstream,
			port_a_downstream, port_b_downstream, hub_mode});
		chk("speeds", {3'h0, h ? SPEED_HIGH_ONLY : SPEED_ALL, SPEED_ALL},
			{3'h0, port_a_speeds, port_b_speeds});
		chk("dirs", {6'h00, h, !h, !h}, {6'h00, sideband_down_a_oe_n,
			sideband_up_a_oe_n, sideband_up_b_oe_n});
		chk("pll", 9'h128, {pll_enable, pll_multiplier});
		chk("status idle", 9'h001, {8'h00, status_role_strap_oe_n});
	endtask
	task link_up(input logic r);
		peer_role <= r;
		peer_en <= 1'b1;
		for (int i = 0; i < 300; i++) begin
			@(posedge clock);
			if (link_connected === 1'b1) break;
		end
		@(posedge clock);
		chk("connected", 9'h001, {8'h00, link_connected});
		chk("status on", 9'h000, {8'h00, status_role_strap_oe_n});
	endtask
	// ==========================================================
	// Tests
	initial begin
		do_reset(1'b1);
		cfg(1'b1);
		done("host config");
		pll_locked <= 1'b1;
		peer_lvl <= 3'h2;
		link_up(1'b0);
		repeat (40) @(posedge clock);
		chk("up outs", 9'h001, {7'h00, sideband_up_b_out, sideband_up_a_out});
		peer_lvl <= 3'h4;
		lvl <= 3'h1;
		repeat (40) @(posedge clock);
		chk("up outs", 9'h002, {7'h00, sideband_up_b_out, sideband_up_a_out});
		chk("sb word", 9'h043, {2'h0, peer_model_i.last_sb[8:3],
			peer_model_i.last_sb[0]});
		done("host sideband");
		stall <= 1'b1;
		usb_rx_valid <= 1'b1;
		acc = 0;
		for (int i = 0; i < 40; i++) begin
			usb_rx_data <= acc[7:0];
			@(posedge clock);
			if (usb_rx_ready === 1'b1) acc++;
		end
		usb_rx_valid <= 1'b0;
		chk("fill", 9'h001, {8'h00, acc >= 32 && acc <= 33});
		chk("refused", 9'h000, {8'h00, usb_rx_ready});
		stall <= 1'b0;
		repeat (acc + 24) @(posedge clock);
		chk("drained", acc[8:0], peer_model_i.got.size());
		for (int i = 0; i < acc; i++) begin
			chk("data word", {1'b0, i[7:0]}, peer_model_i.got[i]);
		end
		done("fifo");
		peer_model_i.send(9'h0A5);
		peer_model_i.send(9'h03C);
		repeat (8) @(posedge clock);
		chk("rx count", 9'h002, tx_seen.size());
		chk("rx byte 0", 9'h0A5, {1'b0, tx_seen[0]});
		chk("rx byte 1", 9'h03C, {1'b0, tx_seen[1]});
		done("link to usb");
		peer_en <= 1'b0;
		repeat (TT + 40) @(posedge clock);
		chk("lost", 9'h001, {7'h00, link_connected,
			status_role_strap_oe_n});
		chk("held outs", 9'h002, {7'h00, sideband_up_b_out,
			sideband_up_a_out});
		strap_pull <= 1'b0;
		repeat (6) @(posedge clock);
		chk("role kept", 9'h001, {8'h00, port_a_upstream});
		done("link lost");
		do_reset(1'b0);
		cfg(1'b0);
		peer_lvl <= 3'h1;
		lvl <= 3'h2;
		link_up(1'b1);
		repeat (40) @(posedge clock);
		chk("down out", 9'h001, {8'h00, sideband_down_a_out});
		chk("sb word", 9'h081, {1'b0, peer_model_i.last_sb[8:3],
			peer_model_i.last_sb[2:1]});
		done("remote");
		results;
	end
	initial begin
		repeat (20000) @(posedge clock);
		n_mismatch++;
		results;
	end
endmodule
